// ==== rtl/pfm_consts.vh ====
`ifndef PFM_CONSTS_VH
`define PFM_CONSTS_VH

// register indices as printed; byte address is four times the index
`define PFM_IDX_PIN1_CFG      8'h0c
`define PFM_IDX_PIN2_CFG      8'h0d
`define PFM_IDX_DIRECT_IO     8'h20
`define PFM_IDX_IRQ_STATUS    8'h21
`define PFM_IDX_IRQ_MASK      8'h22
`define PFM_IDX_STATE         8'h23

// configuration fields
`define PFM_DRV_HI            7
`define PFM_DRV_LO            6
`define PFM_PUP_BIT           5
`define PFM_SEL_HI            4
`define PFM_SEL_LO            0
`define PFM_CFG_RESET         8'h00

// function select codes
`define PFM_FN_SPECIAL        5'h00
`define PFM_FN_WAKE           5'h01
`define PFM_FN_LOWBAT         5'h02
`define PFM_FN_DIN            5'h03
`define PFM_FN_IRQ_FALL       5'h04
`define PFM_FN_IRQ_RISE       5'h05
`define PFM_FN_IRQ_CHANGE     5'h06
`define PFM_FN_ADC_IN         5'h07
`define PFM_FN_DOUT           5'h0a
`define PFM_FN_VREF           5'h0e
`define PFM_FN_TXCLK          5'h0f
`define PFM_FN_TXDATA         5'h10
`define PFM_FN_RETX           5'h11
`define PFM_FN_TXSTATE        5'h12
`define PFM_FN_FIFO_AF        5'h13
`define PFM_FN_VDD            5'h1d

// interrupt status bit positions
`define PFM_IRQ_PIN1_EXT      0
`define PFM_IRQ_PIN2_EXT      1
`define PFM_IRQ_PIN1_RETX     2
`define PFM_IRQ_PIN2_RETX     3
`define PFM_IRQ_WIDTH         4

// ahb constants
`define PFM_HTRANS_NONSEQ     2'b10
`define PFM_ADDR_IDX_HI       9
`define PFM_ADDR_IDX_LO       2

`endif

// ==== rtl/pfm_pin_slice.v ====
`timescale 1ns/10ps
`include "pfm_consts.vh"

// one pin: decodes its select into pin drive and input events
module pfm_pin_slice #(
	parameter INVERT_SPECIAL = 1'b0
) (
	// clock and reset
	input  wire       clock,
	input  wire       resetn,
	// configuration
	input  wire [7:0] cfg,
	input  wire       special_src,
	input  wire       dout_level,
	// internal sources
	input  wire       wake_expired,
	input  wire       low_battery,
	input  wire       tx_data_clock,
	input  wire       tx_state,
	input  wire       fifo_almost_full,
	// pin
	input  wire       pin_in,
	output reg        pin_out,
	output reg        pin_oe,
	output wire       pin_pullup_en,
	output wire       pin_analog_in,
	output wire       pin_vref_en,
	output wire [1:0] pin_drive,
	// events toward the core
	output reg        din_level_q,
	output reg        ext_irq_event,
	output reg        retx_event,
	output wire       tx_data_valid,
	output reg        tx_data_q
);

	wire [4:0] sel = cfg[`PFM_SEL_HI:`PFM_SEL_LO];
	reg        prev_q;

	function is_digital_input;
		input [4:0] s;
		begin
			is_digital_input = (s == `PFM_FN_DIN) || (s == `PFM_FN_IRQ_FALL) ||
				(s == `PFM_FN_IRQ_RISE) || (s == `PFM_FN_IRQ_CHANGE) ||
				(s == `PFM_FN_TXDATA) || (s == `PFM_FN_RETX);
		end
	endfunction

	assign pin_drive     = cfg[`PFM_DRV_HI:`PFM_DRV_LO];
	assign pin_pullup_en = cfg[`PFM_PUP_BIT] & is_digital_input(sel);
	assign pin_analog_in = (sel == `PFM_FN_ADC_IN);
	assign pin_vref_en   = (sel == `PFM_FN_VREF);
	assign tx_data_valid = (sel == `PFM_FN_TXDATA);

	// output path; codes 1e and 1f are driven low, other unlisted codes are held undriven
	always @* begin
		pin_out = 1'b0;
		pin_oe  = 1'b1;
		case (sel)
			`PFM_FN_SPECIAL:  pin_out = special_src ^ INVERT_SPECIAL;
			`PFM_FN_WAKE:     pin_out = wake_expired;
			`PFM_FN_LOWBAT:   pin_out = low_battery;
			`PFM_FN_DOUT:     pin_out = dout_level;
			`PFM_FN_TXCLK:    pin_out = tx_data_clock;
			`PFM_FN_TXSTATE:  pin_out = tx_state;
			`PFM_FN_FIFO_AF:  pin_out = fifo_almost_full;
			`PFM_FN_VDD:      pin_out = 1'b1;
			5'h1e, 5'h1f:     pin_out = 1'b0;
			default:          pin_oe  = 1'b0;
		endcase
	end

	// edge detect on a pin that is already synchronous to clock
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			prev_q        <= 1'b0;
			din_level_q   <= 1'b0;
			ext_irq_event <= 1'b0;
			retx_event    <= 1'b0;
			tx_data_q     <= 1'b0;
		end else begin
			prev_q        <= pin_in;
			din_level_q   <= (sel == `PFM_FN_DIN) ? pin_in : din_level_q;
			tx_data_q     <= pin_in;
			retx_event    <= (sel == `PFM_FN_RETX) & pin_in & ~prev_q;
			case (sel)
				`PFM_FN_IRQ_FALL:   ext_irq_event <= prev_q & ~pin_in;
				`PFM_FN_IRQ_RISE:   ext_irq_event <= ~prev_q & pin_in;
				`PFM_FN_IRQ_CHANGE: ext_irq_event <= prev_q ^ pin_in;
				default:            ext_irq_event <= 1'b0;
			endcase
		end
	end

endmodule // pfm_pin_slice

// ==== rtl/pfm_pin_mux.v ====
// Behaviour
// - pin config: drive strength 7:6, pull-up 5, function select 4:0, all read/write
// - pull-up connects only when enabled and pin is a digital input
// - pin one, select 00000: drives inverted power-on-reset indication
// - pin two, select 00000: drives microcontroller clock output
// - select 00001: pin high once wake-up timer expired
// - select 00010: pin high while battery below threshold
// - 00011 direct input readable; 01010 direct output set by software
// - 00100/00101/00110: interrupt on falling, rising, any change
// - 00111 routes pin to converter; 01110 drives reference voltage
// - 01111 outputs transmit data clock; 10000 accepts data in step
// - 10001: pin is retransmission request input
// - 10010 shows transmit state; 10011 shows fifo almost full
`timescale 1ns/10ps
`include "pfm_consts.vh"

module pfm_pin_mux (
	// clock and reset
	input  wire        clock,
	input  wire        resetn,
	// ahb-lite slave
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire [31:0] hrdata,
	output wire        hreadyout,
	output wire        hresp,
	// internal sources
	input  wire        por_active,
	input  wire        mcu_clock,
	input  wire        wake_expired,
	input  wire        low_battery,
	input  wire        tx_data_clock,
	input  wire        tx_state,
	input  wire        fifo_almost_full,
	// pin one
	input  wire        general_pin_one_in,
	output wire        general_pin_one_out,
	output wire        general_pin_one_oe,
	output wire        general_pin_one_pullup,
	output wire        general_pin_one_analog,
	output wire        general_pin_one_vref,
	output wire [1:0]  pin1_drive_strength,
	// pin two
	input  wire        general_pin_two_in,
	output wire        general_pin_two_out,
	output wire        general_pin_two_oe,
	output wire        general_pin_two_pullup,
	output wire        general_pin_two_analog,
	output wire        general_pin_two_vref,
	output wire [1:0]  pin2_drive_strength,
	// toward the transmitter
	output reg         tx_data,
	output reg         tx_data_valid,
	output reg         retx_request,
	// interrupt
	output wire        irq
);

	reg  [7:0]  pin1_cfg_q;
	reg  [7:0]  pin2_cfg_q;
	reg  [1:0]  dout_q;
	reg  [`PFM_IRQ_WIDTH-1:0] status_q;
	reg  [`PFM_IRQ_WIDTH-1:0] mask_q;
	reg  [`PFM_IRQ_WIDTH-1:0] status_d;
	reg         wr_pend_q;
	reg  [7:0]  idx_q;
	reg  [31:0] rdata_q;
	reg  [31:0] rdata_d;

	wire        p1_din, p2_din;
	wire        p1_ext, p2_ext;
	wire        p1_retx, p2_retx;
	wire        p1_txv, p2_txv;
	wire        p1_txd, p2_txd;
	wire [`PFM_IRQ_WIDTH-1:0] events;

	// bus decode: single-cycle address phase, zero-wait data phase
	wire        take    = hsel & hready & (htrans == `PFM_HTRANS_NONSEQ);
	wire [7:0]  idx_in  = haddr[`PFM_ADDR_IDX_HI:`PFM_ADDR_IDX_LO];

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = rdata_q;

	function [31:0] read_mux;
		input [7:0] idx;
		begin
			case (idx)
				`PFM_IDX_PIN1_CFG:   read_mux = {24'h000000, pin1_cfg_q};
				`PFM_IDX_PIN2_CFG:   read_mux = {24'h000000, pin2_cfg_q};
				`PFM_IDX_DIRECT_IO:  read_mux = {28'h0000000, p2_din, p1_din, dout_q};
				`PFM_IDX_IRQ_STATUS: read_mux = {28'h0000000, status_q};
				`PFM_IDX_IRQ_MASK:   read_mux = {28'h0000000, mask_q};
				`PFM_IDX_STATE:      read_mux = {24'h000000, fifo_almost_full, tx_state,
				                                 low_battery, wake_expired,
				                                 general_pin_two_in, general_pin_one_in,
				                                 p2_txv, p1_txv};
				default:             read_mux = 32'h00000000;
			endcase
		end
	endfunction

	// read data is registered at the address phase so it stands in the data phase
	always @* begin
		rdata_d = rdata_q;
		if (take && !hwrite)
			rdata_d = read_mux(idx_in);
	end

	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			wr_pend_q <= 1'b0;
			idx_q     <= 8'h00;
			rdata_q   <= 32'h00000000;
		end else begin
			wr_pend_q <= take & hwrite;
			idx_q     <= take ? idx_in : idx_q;
			rdata_q   <= rdata_d;
		end
	end

	// status: set wins over a write-one clear in the same cycle
	always @* begin
		status_d = status_q;
		if (wr_pend_q && idx_q == `PFM_IDX_IRQ_STATUS)
			status_d = status_q & ~hwdata[`PFM_IRQ_WIDTH-1:0];
		status_d = status_d | events;
	end

	assign events[`PFM_IRQ_PIN1_EXT]  = p1_ext;
	assign events[`PFM_IRQ_PIN2_EXT]  = p2_ext;
	assign events[`PFM_IRQ_PIN1_RETX] = p1_retx;
	assign events[`PFM_IRQ_PIN2_RETX] = p2_retx;
	assign irq = |(status_q & mask_q);

	// register writes; reserved select codes are stored as written, never trapped
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pin1_cfg_q <= `PFM_CFG_RESET;
			pin2_cfg_q <= `PFM_CFG_RESET;
			dout_q     <= 2'b00;
			mask_q     <= {`PFM_IRQ_WIDTH{1'b0}};
			status_q   <= {`PFM_IRQ_WIDTH{1'b0}};
		end else begin
			status_q <= status_d;
			if (wr_pend_q) begin
				case (idx_q)
					`PFM_IDX_PIN1_CFG:  pin1_cfg_q <= hwdata[7:0];
					`PFM_IDX_PIN2_CFG:  pin2_cfg_q <= hwdata[7:0];
					`PFM_IDX_DIRECT_IO: dout_q     <= hwdata[1:0];
					`PFM_IDX_IRQ_MASK:  mask_q     <= hwdata[`PFM_IRQ_WIDTH-1:0];
					default:            dout_q     <= dout_q;
				endcase
			end
		end
	end

	// direct-modulation data and retransmission request toward the transmitter
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			tx_data       <= 1'b0;
			tx_data_valid <= 1'b0;
			retx_request  <= 1'b0;
		end else begin
			tx_data       <= p1_txv ? p1_txd : p2_txd;
			tx_data_valid <= p1_txv | p2_txv;
			retx_request  <= p1_retx | p2_retx;
		end
	end

	pfm_pin_slice #(
		.INVERT_SPECIAL (1'b1)
	) u_pin_one (
		.clock            (clock),
		.resetn           (resetn),
		.cfg              (pin1_cfg_q),
		.special_src      (por_active),
		.dout_level       (dout_q[0]),
		.wake_expired     (wake_expired),
		.low_battery      (low_battery),
		.tx_data_clock    (tx_data_clock),
		.tx_state         (tx_state),
		.fifo_almost_full (fifo_almost_full),
		.pin_in           (general_pin_one_in),
		.pin_out          (general_pin_one_out),
		.pin_oe           (general_pin_one_oe),
		.pin_pullup_en    (general_pin_one_pullup),
		.pin_analog_in    (general_pin_one_analog),
		.pin_vref_en      (general_pin_one_vref),
		.pin_drive        (pin1_drive_strength),
		.din_level_q      (p1_din),
		.ext_irq_event    (p1_ext),
		.retx_event       (p1_retx),
		.tx_data_valid    (p1_txv),
		.tx_data_q        (p1_txd)
	);

	pfm_pin_slice #(
		.INVERT_SPECIAL (1'b0)
	) u_pin_two (
		.clock            (clock),
		.resetn           (resetn),
		.cfg              (pin2_cfg_q),
		.special_src      (mcu_clock),
		.dout_level       (dout_q[1]),
		.wake_expired     (wake_expired),
		.low_battery      (low_battery),
		.tx_data_clock    (tx_data_clock),
		.tx_state         (tx_state),
		.fifo_almost_full (fifo_almost_full),
		.pin_in           (general_pin_two_in),
		.pin_out          (general_pin_two_out),
		.pin_oe           (general_pin_two_oe),
		.pin_pullup_en    (general_pin_two_pullup),
		.pin_analog_in    (general_pin_two_analog),
		.pin_vref_en      (general_pin_two_vref),
		.pin_drive        (pin2_drive_strength),
		.din_level_q      (p2_din),
		.ext_irq_event    (p2_ext),
		.retx_event       (p2_retx),
		.tx_data_valid    (p2_txv),
		.tx_data_q        (p2_txd)
	);

endmodule // pfm_pin_mux

// ==== tb/pfm_props.sv ====
`timescale 1ns/10ps
module pfm_props (
	// clock, reset, bus
	input wire       clock,
	input wire       resetn,
	input wire       hsel,
	input wire [1:0] htrans,
	input wire       hwrite,
	input wire       hready,
	// sources and pins
	input wire       por_active,
	input wire       mcu_clock,
	input wire       general_pin_one_in,
	input wire       general_pin_two_in,
	input wire       general_pin_one_out,
	input wire       general_pin_one_oe,
	input wire       general_pin_one_pullup,
	input wire       general_pin_one_analog,
	input wire       general_pin_two_out,
	input wire       general_pin_two_oe,
	input wire       general_pin_two_pullup,
	input wire [1:0] pin1_drive_strength,
	input wire       tx_data_valid,
	input wire       retx_request
);
	wire wr_taken = hsel && hready && htrans == 2'h2 && hwrite;
	reg  touched_q;
	// any write may move a config off its reset value
	always @(posedge clock or negedge resetn)
		if (!resetn)
			touched_q <= 1'h0;
		else if (wr_taken)
			touched_q <= 1'h1;
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	chk_reset_pins: assert property (!touched_q |-> general_pin_one_oe && general_pin_two_oe
		&& general_pin_one_out == !por_active && general_pin_two_out == mcu_clock) else $error("reset drive wrong");
	chk_pullup_one: assert property (general_pin_one_pullup |-> !general_pin_one_oe && !general_pin_one_analog)
		else $error("pin one pull-up misplaced");
	chk_pullup_two: assert property (general_pin_two_pullup |-> !general_pin_two_oe)
		else $error("pin two pull-up misplaced");
	chk_analog_free: assert property (general_pin_one_analog |-> !general_pin_one_oe)
		else $error("analog pin driven");
	// back-to-back requests are only legal when they come from different pins
	chk_retx_pulse: assert property (retx_request |=> !retx_request
		|| $past(general_pin_one_in, 3) != $past(general_pin_two_in, 3)) else $error("retransmit pulse too long");
	// request stands two edges after the pin was first seen high
	chk_retx_cause: assert property (retx_request |->
		$past(general_pin_one_in, 2) && !$past(general_pin_one_in, 3)
		|| $past(general_pin_two_in, 2) && !$past(general_pin_two_in, 3)) else $error("retransmit without rising pin");
	chk_txvalid_input: assert property (tx_data_valid |-> !$past(general_pin_one_oe) || !$past(general_pin_two_oe))
		else $error("tx data valid on driven pins");
	chk_drive_write: assert property (!$stable(pin1_drive_strength) |-> $past(wr_taken, 2))
		else $error("drive moved without write");
endmodule // pfm_props

bind pfm_pin_mux pfm_props u_props (.clock, .resetn, .hsel, .htrans, .hwrite, .hready, .por_active, .mcu_clock,
	.general_pin_one_in, .general_pin_two_in, .general_pin_one_out, .general_pin_one_oe, .general_pin_one_pullup,
	.general_pin_one_analog, .general_pin_two_out, .general_pin_two_oe, .general_pin_two_pullup,
	.pin1_drive_strength, .tx_data_valid, .retx_request);

// ==== tb/pfm_pin_party.sv ====
`timescale 1ns/10ps
module pfm_pin_party (
	input wire  clock,
	// device side
	input wire  dev_out,
	input wire  dev_oe,
	input wire  dev_pullup,
	// outside driver
	input wire  ext_en,
	input wire  ext_val,
	output wire level
);
	reg float_q = 1'h0;
	// a released pin must not read as a steady level
	always @(posedge clock)
		float_q <= ~float_q;
	assign level = dev_oe ? dev_out : ext_en ? ext_val : dev_pullup ? 1'h1 : float_q;
endmodule // pfm_pin_party

// ==== tb/tb_top.sv ====
`timescale 1ns/10ps
`include "pfm_consts.vh"
module tb_top;
	localparam logic [7:0] C1 = `PFM_IDX_PIN1_CFG, C2 = `PFM_IDX_PIN2_CFG, IO = `PFM_IDX_DIRECT_IO;
	localparam logic [7:0] ST = `PFM_IDX_IRQ_STATUS, MK = `PFM_IDX_IRQ_MASK;
	logic        clock = 1'h0, resetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
	logic [1:0]  htrans = 2'h0, ext_en = 2'h0, ext_val = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
	logic [6:0]  src = 7'h0;
	logic [4:0]  codes [8] = '{5'h01, 5'h02, 5'h0f, 5'h12, 5'h13, 5'h1d, 5'h1e, 5'h1f};
	wire  [31:0] hrdata;
	wire  [1:0]  pi, po, pe, pu, pa, pv, drv1, drv2;
	wire         hreadyout, hresp, irq, tx_data, tx_data_valid, retx_request;
	int          bad_count = 0, checks = 0, cycles = 0, n;
	pfm_pin_mux dut (.clock, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
		.hrdata, .hreadyout, .hresp, .por_active(src[6]), .mcu_clock(src[5]), .wake_expired(src[4]),
		.low_battery(src[3]), .tx_data_clock(src[2]), .tx_state(src[1]), .fifo_almost_full(src[0]),
		.general_pin_one_in(pi[0]), .general_pin_one_out(po[0]), .general_pin_one_oe(pe[0]),
		.general_pin_one_pullup(pu[0]), .general_pin_one_analog(pa[0]), .general_pin_one_vref(pv[0]),
		.pin1_drive_strength(drv1), .general_pin_two_in(pi[1]), .general_pin_two_out(po[1]),
		.general_pin_two_oe(pe[1]), .general_pin_two_pullup(pu[1]), .general_pin_two_analog(pa[1]),
		.general_pin_two_vref(pv[1]), .pin2_drive_strength(drv2), .tx_data, .tx_data_valid, .retx_request, .irq);
	pfm_pin_party u_far1 (.clock, .dev_out(po[0]), .dev_oe(pe[0]), .dev_pullup(pu[0]), .ext_en(ext_en[0]),
		.ext_val(ext_val[0]), .level(pi[0]));
	pfm_pin_party u_far2 (.clock, .dev_out(po[1]), .dev_oe(pe[1]), .dev_pullup(pu[1]), .ext_en(ext_en[1]),
		.ext_val(ext_val[1]), .level(pi[1]));
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
		hsel <= 1'h1;
		htrans <= `PFM_HTRANS_NONSEQ;
		hwrite <= wr;
		haddr <= {22'h0, idx, 2'h0};
		do @(posedge clock); while (hreadyout !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clock); while (hreadyout !== 1'h1);
		rd = hrdata;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
		bus(1'h0, idx, 32'h0);
		chk("register", exp, rd);
	endtask
	// fields {out, oe, pullup, analog, vref}; cleared mask bits go unchecked
	task automatic pin(input int p, input logic [4:0] exp, input logic [4:0] m);
		@(negedge clock);
		chk("pin", {27'h0, exp & m}, {27'h0, m & {po[p], pe[p], pu[p], pa[p], pv[p]}});
		@(posedge clock);
	endtask
	task automatic complete_run;
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	always #4 clock = ~clock;
	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			bad_count++;
			complete_run;
		end
	end
	initial begin
		repeat (3) @(posedge clock);
		resetn <= 1'h1;
		@(posedge clock);
		rdc(C1, 32'h0);
		rdc(C2, 32'h0);
		src[6:5] <= 2'h3;
		pin(0, 5'h08, 5'h1f);
		pin(1, 5'h18, 5'h1f);
		src[6:5] <= 2'h0;
		pin(0, 5'h18, 5'h1f);
		pin(1, 5'h08, 5'h1f);
		bus(1'h1, C1, 32'he3);
		bus(1'h1, C2, 32'h9f);
		rdc(C1, 32'he3);
		rdc(C2, 32'h9f);
		chk("drive", 32'he, {28'h0, drv1, drv2});
		pin(0, 5'h04, 5'h0f);
		pin(1, 5'h08, 5'h1f);
		rdc(IO, 32'h4);
		ext_en <= 2'h3;
		bus(1'h1, C1, 32'h03);
		pin(0, 5'h00, 5'h0e);
		rdc(IO, 32'h0);
		for (int p = 0; p < 2; p++)
			for (int k = 0; k < 8; k++) begin
				bus(1'h1, C1 + p[7:0], {27'h0, codes[k]});
				for (int v = 0; v < 2; v++) begin
					src[4:0] <= {5{v[0]}};
					pin(p, {k == 5 || (k < 5 && v[0]), 4'h8}, 5'h1f);
				end
			end
		bus(1'h1, C1, 32'h0a);
		for (int v = 1; v >= 0; v--) begin
			bus(1'h1, IO, {31'h0, v[0]});
			pin(0, {v[0], 4'h8}, 5'h1f);
		end
		bus(1'h1, MK, 32'hf);
		for (int k = 0; k < 3; k++) begin
			bus(1'h1, C1, {30'h1, k[1:0]});
			bus(1'h1, ST, 32'hf);
			ext_val[0] <= 1'h1;
			repeat (3) @(posedge clock);
			rdc(ST, {31'h0, k != 0});
			bus(1'h1, ST, 32'hf);
			ext_val[0] <= 1'h0;
			repeat (3) @(posedge clock);
			rdc(ST, {31'h0, k != 1});
			chk("irq", {31'h0, k != 1}, {31'h0, irq});
		end
		bus(1'h1, MK, 32'h0);
		@(posedge clock);
		chk("irq", 32'h0, {31'h0, irq});
		bus(1'h1, ST, 32'h1);
		rdc(ST, 32'h0);
		bus(1'h1, C1, 32'h07);
		pin(0, 5'h02, 5'h0f);
		bus(1'h1, C1, 32'h0e);
		pin(0, 5'h01, 5'h03);
		bus(1'h1, C1, 32'h08);
		rdc(C1, 32'h08);
		pin(0, 5'h00, 5'h0f);
		bus(1'h1, C2, 32'h10);
		for (int v = 1; v >= 0; v--) begin
			ext_val[1] <= v[0];
			repeat (3) @(posedge clock);
			chk("tx data", {30'h0, 1'h1, v[0]}, {30'h0, tx_data_valid, tx_data});
		end
		bus(1'h1, C1, 32'h11);
		bus(1'h1, ST, 32'hf);
		ext_val[0] <= 1'h1;
		n = 0;
		// looked at mid-cycle, away from the edge that launches the pulse
		repeat (5) begin
			@(negedge clock);
			if (retx_request === 1'h1)
				n++;
		end
		@(posedge clock);
		chk("retx pulses", 32'h1, n);
		rdc(ST, 32'h4);
		bus(1'h1, 8'h40, 32'hffffffff);
		rdc(8'h40, 32'h0);
		chk("bus answer", 32'h2, {30'h0, hreadyout, hresp});
		complete_run;
	end
endmodule // tb_top
